// >>> core/swl_engine.sv
// read-byte and triplet command engine for the single-wire master
`timescale 1ns/100ps
// How it works
// R1: code 96h runs eight read slots
// R2: eight sampled bits stored as read data
// R3: read slot equals write-one slot waveform
// R4: busy at 96h: no ack, no activity
// R5: read byte ends within eight slots+margin
// R6: line activity starts within 262.5ns
// R7: pointer goes to status after read byte
// R8: busy held through the eight slots
// R9: code 78h: two reads then one write
// R10: both reads zero: write follows direction bit
// R11: 01 writes zero; 10 and 11 write one
// R12: busy at 78h: no acks, ignored
// R13: triplet starts within margin, ends 3 slots
// R14: busy three slots; result bits per sample
// R15: host repeats triplet 64 times per search
// R16: direction is bit 7, rest ignored
// R17: speed and pullup settings apply
module swl_engine
(
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic [3:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic line_i, // single-wire line level (pin)
    output logic line_o, // line output value, always 0
    output logic line_oe, // high while pulling the line low
    output logic pullup_o // active pullup drive
);
    typedef enum logic [1:0] {E_IDLE, E_WAIT, E_SLOT} eng_state_t;
    typedef struct packed
    {
        eng_state_t st;
        logic is_trip;
        logic [3:0] nslot;
        logic [2:0] idx;
        logic [7:0] shift;
        logic [7:0] read_data;
        logic [7:0] cfg;
        logic busy;
        logic single_bit_result;
        logic triplet_second_bit;
        logic dir;
        logic vdir;
        logic ptr;
        logic acked;
        logic slot_go;
        logic slot_bit;
        logic [7:0] rdata;
        logic oe;
        logic pu;
    } eng_t;
    eng_t q;
    eng_t d;
    logic line_s;
    logic s_done;
    logic s_stb;
    logic s_val;
    logic s_low;
    logic s_pu;

    swl_sync u_sync
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(line_i),
        .dout(line_s)
    );

    swl_slot u_slot
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(q.slot_go),
        .wbit(q.slot_bit),
        .fast(q.cfg[swl_pkg::CFG_SPEED]),
        .active_pullup_select(q.cfg[swl_pkg::CFG_APU]),
        .line_in(line_s),
        .done(s_done),
        .sample_stb(s_stb),
        .sample_val(s_val),
        .drive_low(s_low),
        .pullup_en(s_pu)
    );

    // triplet write direction from the two read results
    function automatic logic trip_wbit(input logic a, input logic b,
        input logic v);
        if (!a && !b)
            return v; // [R10]
        return a; // [R11]
    endfunction

    // --------------------------------------------------------------
    // command decode, slot sequencing, register port
    // --------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.slot_go = 1'b0;
        d.oe = s_low;
        d.pu = s_pu;
        if (reg_wr && reg_addr == swl_pkg::REG_CMD)
        begin
            d.acked = 1'b0;
            if (!q.busy) // [R4]
            begin
                if (reg_wdata == swl_pkg::CMD_READ_BYTE) // [R1]
                begin
                    d.acked = 1'b1;
                    d.st = E_WAIT;
                    d.is_trip = 1'b0;
                    d.nslot = 4'h8;
                    d.idx = 3'h0;
                    d.busy = 1'b1; // [R8]
                    d.ptr = swl_pkg::PTR_STATUS; // [R7]
                end
            end
        end
        // triplet command arrives alone; direction byte comes earlier via REG_ACK
        if (reg_wr && reg_addr == swl_pkg::REG_PARAM)
        begin
            d.acked = 1'b0;
            if (!q.busy) // [R12]
            begin
                if (reg_wdata == swl_pkg::CMD_TRIPLET) // [R9]
                begin
                    d.acked = 1'b1;
                    d.st = E_WAIT;
                    d.is_trip = 1'b1;
                    d.nslot = 4'h3;
                    d.idx = 3'h0;
                    d.busy = 1'b1; // [R14]
                    d.ptr = swl_pkg::PTR_STATUS;
                end
            end
        end
        if (reg_wr && reg_addr == swl_pkg::REG_CONFIG && !q.busy)
            d.cfg = reg_wdata; // [R17]
        if (reg_wr && reg_addr == swl_pkg::REG_PTR)
            d.ptr = reg_wdata[0]; // [R7]
        // direction byte ignored while a command runs
        if (reg_wr && reg_addr == swl_pkg::REG_ACK && !q.busy)
            d.vdir = reg_wdata[swl_pkg::DIR_BIT]; // [R16]
        unique case (q.st)
            E_IDLE:
            begin
            end
            E_WAIT:
            begin
                // first slot next cycle, well inside 262.5ns
                d.slot_go = 1'b1; // [R6] [R13]
                d.slot_bit = 1'b1; // [R3]
                d.st = E_SLOT;
            end
            E_SLOT:
            begin
                if (s_stb)
                begin
                    if (!q.is_trip)
                        d.shift = {s_val, q.shift[7:1]};
                    else if (q.idx == 3'h0)
                        d.single_bit_result = s_val; // [R14]
                    else if (q.idx == 3'h1)
                    begin
                        d.triplet_second_bit = s_val; // [R14]
                        d.dir = trip_wbit(q.single_bit_result, s_val, q.vdir);
                    end
                end
                if (s_done)
                begin
                    d.idx = q.idx + 3'h1;
                    if (q.nslot == 4'h1)
                    begin
                        d.st = E_IDLE;
                        d.busy = 1'b0; // [R5] [R8] [R13]
                        if (!q.is_trip)
                            d.read_data = q.shift; // [R2]
                    end
                    else
                    begin
                        d.nslot = q.nslot - 4'h1;
                        d.slot_go = 1'b1;
                        d.slot_bit = (q.is_trip && q.idx == 3'h1) ?
                            q.dir : 1'b1; // [R10] [R11]
                    end
                end
            end
            default:
                d.st = E_IDLE;
        endcase
        d.rdata = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == swl_pkg::REG_CONFIG)
                d.rdata = q.cfg;
            else if (reg_addr == swl_pkg::REG_ACK)
                d.rdata = {7'h00, q.acked};
            else if (reg_addr == swl_pkg::REG_STATUS ||
                (reg_addr == swl_pkg::REG_READ_DATA &&
                 q.ptr == swl_pkg::PTR_STATUS))
                d.rdata = {q.dir, q.triplet_second_bit, q.single_bit_result, 4'h0, q.busy};
            else if (reg_addr == swl_pkg::REG_READ_DATA)
                d.rdata = q.read_data; // [R7]
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '{st: E_IDLE, is_trip: 1'b0, nslot: 4'h0, idx: 3'h0,
                shift: 8'h00, read_data: 8'h00,
                cfg: swl_pkg::CONFIG_RESET, busy: 1'b0, single_bit_result: 1'b0,
                triplet_second_bit: 1'b0, dir: 1'b0, vdir: 1'b0,
                ptr: swl_pkg::PTR_STATUS, acked: 1'b0, slot_go: 1'b0,
                slot_bit: 1'b1, rdata: 8'h00, oe: 1'b0, pu: 1'b0};
        else
            q <= d;
    end

    assign reg_rdata = q.rdata;
    assign line_o = 1'b0;
    assign line_oe = q.oe;
    assign pullup_o = q.pu;
endmodule

// >>> core/swl_pkg.sv
// shared constants for the single-wire read-byte / triplet engine
package swl_pkg;
    // command codes
    localparam logic [7:0] CMD_READ_BYTE = 8'h96;
    localparam logic [7:0] CMD_TRIPLET = 8'h78;
    // direction byte: direction value bit
    localparam int DIR_BIT = 7;
    // register offsets on the plain register port
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_PARAM = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_READ_DATA = 4'h3;
    localparam logic [3:0] REG_CONFIG = 4'h4;
    localparam logic [3:0] REG_PTR = 4'h5;
    localparam logic [3:0] REG_ACK = 4'h6;
    // status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_SBR = 5;
    localparam int ST_TSB = 6;
    localparam int ST_DIR = 7;
    // config field positions
    localparam int CFG_APU = 0;
    localparam int CFG_SPEED = 3;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    // read pointer selections
    localparam logic PTR_STATUS = 1'b0;
    localparam logic PTR_READ_DATA = 1'b1;
    // timing, us (start margin in ps), and derived counts at 125 MHz
    localparam int CLK_PERIOD_PS = 8000;
    localparam int START_MARGIN_PS = 262500;
    localparam int START_MARGIN_CYC = START_MARGIN_PS / CLK_PERIOD_PS;
    localparam int SLOT_STD_NS = 70;
    localparam int SLOT_FAST_NS = 10;
    localparam int LOW_STD_NS = 8;
    localparam int LOW_FAST_NS = 1;
    localparam int SAMPLE_STD_NS = 14;
    localparam int SAMPLE_FAST_NS = 2;
    localparam int W0_LOW_STD_NS = 60;
    localparam int W0_LOW_FAST_NS = 8;
    localparam int RECOVER_NS = 2;
    function automatic int ns_cyc(input int ns);
        return ((ns * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction
    localparam int SLOT_STD_CYC = ns_cyc(SLOT_STD_NS * 1000);
    localparam int SLOT_FAST_CYC = ns_cyc(SLOT_FAST_NS * 1000);
    localparam int LOW_STD_CYC = ns_cyc(LOW_STD_NS * 1000);
    localparam int LOW_FAST_CYC = ns_cyc(LOW_FAST_NS * 1000);
    localparam int SAMPLE_STD_CYC = ns_cyc(SAMPLE_STD_NS * 1000);
    localparam int SAMPLE_FAST_CYC = ns_cyc(SAMPLE_FAST_NS * 1000);
    localparam int W0_STD_CYC = ns_cyc(W0_LOW_STD_NS * 1000);
    localparam int W0_FAST_CYC = ns_cyc(W0_LOW_FAST_NS * 1000);
    localparam int RECOVER_CYC = ns_cyc(RECOVER_NS * 1000);
    localparam int TW = 16;
endpackage

// >>> core/swl_slot.sv
// one single-wire time slot: write-one/read or write-zero, with sample
`timescale 1ns/100ps
module swl_slot
(
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic start, // one-cycle slot request
    input wire logic wbit, // 1: write-one/read slot, 0: write-zero
    input wire logic fast, // speed select
    input wire logic active_pullup_select, // active pullup select
    input wire logic line_in, // synchronised line level
    output logic done, // one-cycle pulse at slot end
    output logic sample_stb, // one-cycle pulse at sample point
    output logic sample_val, // sampled line level
    output logic drive_low, // pull the line low
    output logic pullup_en // active pullup drive
);
    typedef enum logic [1:0] {S_IDLE, S_LOW, S_REL} slot_state_t;
    typedef struct packed
    {
        slot_state_t st;
        logic [swl_pkg::TW-1:0] cnt;
        logic wbit;
        logic fast;
        logic done;
        logic stb;
        logic val;
        logic low;
        logic pu;
    } slot_t;
    slot_t q;
    slot_t d;
    logic [swl_pkg::TW-1:0] low_len;
    logic [swl_pkg::TW-1:0] smp_at;
    logic [swl_pkg::TW-1:0] slot_len;

    function automatic logic [swl_pkg::TW-1:0] pick(input logic f,
        input int a, input int b);
        return f ? swl_pkg::TW'(b) : swl_pkg::TW'(a);
    endfunction

    always_comb
    begin
        // write-one and read slots share one waveform
        low_len = q.wbit ? pick(q.fast, swl_pkg::LOW_STD_CYC,
            swl_pkg::LOW_FAST_CYC) : pick(q.fast, swl_pkg::W0_STD_CYC,
            swl_pkg::W0_FAST_CYC); // [R3]
        smp_at = pick(q.fast, swl_pkg::SAMPLE_STD_CYC,
            swl_pkg::SAMPLE_FAST_CYC);
        slot_len = pick(q.fast, swl_pkg::SLOT_STD_CYC,
            swl_pkg::SLOT_FAST_CYC); // [R17]
        d = q;
        d.done = 1'b0;
        d.stb = 1'b0;
        d.pu = 1'b0;
        unique case (q.st)
            S_IDLE:
            begin
                if (start)
                begin
                    d.st = S_LOW;
                    d.cnt = '0;
                    d.wbit = wbit;
                    d.fast = fast;
                    d.low = 1'b1;
                end
            end
            S_LOW:
            begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt + 1'b1 >= low_len)
                begin
                    d.st = S_REL;
                    d.low = 1'b0;
                end
            end
            S_REL:
            begin
                d.cnt = q.cnt + 1'b1;
                // active pullup briefly after release
                d.pu = active_pullup_select && (q.cnt < low_len +
                    swl_pkg::TW'(swl_pkg::RECOVER_CYC)); // [R17]
                if (q.cnt == smp_at)
                begin
                    d.stb = 1'b1;
                    d.val = line_in;
                end
                if (q.cnt + 1'b1 >= slot_len)
                begin
                    d.st = S_IDLE;
                    d.done = 1'b1;
                    d.pu = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '{st: S_IDLE, cnt: '0, wbit: 1'b1, fast: 1'b0,
                done: 1'b0, stb: 1'b0, val: 1'b0, low: 1'b0, pu: 1'b0};
        else
            q <= d;
    end

    assign done = q.done;
    assign sample_stb = q.stb;
    assign sample_val = q.val;
    assign drive_low = q.low;
    assign pullup_en = q.pu;
endmodule

// >>> core/swl_sync.sv
// two-flop synchroniser for the single-wire line input
`timescale 1ns/100ps
module swl_sync
(
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic din, // asynchronous input
    output logic dout // synchronised level
);
    typedef struct packed
    {
        logic s1;
        logic s2;
    } sync_t;
    sync_t st_q;
    sync_t st_d;

    always_comb
    begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '{s1: 1'b1, s2: 1'b1};
        else
            st_q <= st_d;
    end

    assign dout = st_q.s2;
endmodule

// >>> tb/swl_engine_properties.sv
// concurrent checks on the read-byte / triplet engine ports
`timescale 1ns/100ps
module swl_engine_properties
(
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic [3:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic line_i, // line level
    input wire logic line_o, // line output value
    input wire logic line_oe, // pulling line low
    input wire logic pullup_o // active pullup
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // command tracking
    // ----------------------------------------------------------------
    localparam int MARGIN = swl_pkg::START_MARGIN_CYC;
    localparam int QUIET = swl_pkg::SLOT_FAST_CYC;
    localparam int SLOT = swl_pkg::SLOT_STD_CYC;
    localparam int W1MAX = swl_pkg::LOW_STD_CYC + 2;
    logic [15:0] idle_q, low_q;
    logic [31:0] elapsed_q;
    logic [3:0] pulses_q, limit_q;
    logic oe_q, quiet, rd_cmd, tr_cmd;
    assign quiet = idle_q >= 16'(QUIET);
    assign rd_cmd = reg_wr && reg_addr == swl_pkg::REG_CMD
        && reg_wdata == swl_pkg::CMD_READ_BYTE;
    assign tr_cmd = reg_wr && reg_addr == swl_pkg::REG_PARAM
        && reg_wdata == swl_pkg::CMD_TRIPLET;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idle_q <= 16'(QUIET);
            low_q <= 16'h0000;
            elapsed_q <= 32'h0000_0000;
            pulses_q <= 4'h0;
            limit_q <= 4'h0;
            oe_q <= 1'b0;
        end
        else
        begin
            oe_q <= line_oe;
            low_q <= line_oe ? low_q + 16'h0001 : 16'h0000;
            elapsed_q <= elapsed_q + 32'h0000_0001;
            if (line_oe)
                idle_q <= 16'h0000;
            else if (!quiet)
                idle_q <= idle_q + 16'h0001;
            if (line_oe && !oe_q)
                pulses_q <= pulses_q + 4'h1;
            if (quiet && (rd_cmd || tr_cmd))
            begin
                idle_q <= 16'h0000;
                pulses_q <= 4'h0;
                elapsed_q <= 32'h0000_0000;
                limit_q <= rd_cmd ? 4'h8 : 4'h3;
            end
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_read_starts: assert property (
        quiet && rd_cmd |-> ##[1:MARGIN] line_oe)
        else $error("read byte did not start the line in time");
    a_trip_starts: assert property (
        quiet && tr_cmd |-> ##[1:MARGIN] line_oe)
        else $error("triplet did not start the line in time");
    a_slot_count: assert property (
        $rose(line_oe) |-> pulses_q < limit_q)
        else $error("more slots than the command allows");
    a_slots_in_time: assert property (
        $rose(line_oe) |-> elapsed_q <= 32'(limit_q * SLOT + MARGIN))
        else $error("slot started after the command duration");
    a_read_slot_short: assert property (
        line_oe && limit_q == 4'h8 |-> low_q <= 16'(W1MAX))
        else $error("read slot held the line low too long");
    a_pullup_apart: assert property (
        pullup_o |-> !line_oe)
        else $error("pullup driven while pulling low");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the read cycle");
    a_line_o_zero: assert property (
        line_oe |-> line_o == 1'b0)
        else $error("line driven high");
    a_pullup_after: assert property (
        $rose(pullup_o) |-> $past(line_oe, 2))
        else $error("pullup not right after a release");
endmodule
bind swl_engine swl_engine_properties u_props (.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_i(line_i), .line_o(line_o), .line_oe(line_oe),
    .pullup_o(pullup_o));

// >>> tb/swl_engine_tb.sv
// self-checking bench for the read-byte and triplet engine
`timescale 1ns/100ps
`define CHK(a, b) chk((a) === (b))
module swl_engine_tb;
    localparam int W1MAX = (swl_pkg::LOW_FAST_CYC + swl_pkg::W0_FAST_CYC) / 2;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fast = 1'b1;
    logic restart = 1'b0;
    logic [7:0] pattern = 8'hFF;
    logic [7:0] reg_rdata, pulses, st;
    logic [15:0] last_len, gap;
    logic line_i, line_o, line_oe, pullup_o, pu_seen;
    logic [1:0] tb_b [5] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h3};
    logic tb_v [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    int miscompares = 0;
    int num_checks = 0;
    initial forever #4 core_clk = ~core_clk;
    swl_engine u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_i(line_i),
        .line_o(line_o), .line_oe(line_oe), .pullup_o(pullup_o));
    swl_slave_model u_slave (.core_clk(core_clk), .line_oe(line_oe),
        .pullup_o(pullup_o), .fast(fast), .pattern(pattern),
        .restart(restart), .line_lvl(line_i), .pulses(pulses),
        .last_len(last_len), .gap(gap), .pu_seen(pu_seen));
    // ----------------------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic ok);
        num_checks++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("MISMATCH at %0t: value differs", $time);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        st = 8'hFF;
        while (st[swl_pkg::ST_BUSY] !== 1'b0 && n < 40000)
        begin
            rd(swl_pkg::REG_STATUS, st);
            n++;
        end
        `CHK(st[swl_pkg::ST_BUSY], 1'b0);
        repeat (swl_pkg::SLOT_FAST_CYC + 2) @(posedge core_clk);
    endtask
    task automatic arm(input logic [7:0] cfg, input logic [7:0] p);
        @(posedge core_clk);
        fast <= cfg[swl_pkg::CFG_SPEED];
        pattern <= p;
        restart <= 1'b1;
        @(posedge core_clk);
        restart <= 1'b0;
        wr(swl_pkg::REG_CONFIG, cfg);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_read_byte();
        logic [7:0] s2;
        arm(8'h08, 8'hA5);
        wr(swl_pkg::REG_CMD, swl_pkg::CMD_READ_BYTE);
        rd(swl_pkg::REG_ACK, st);
        `CHK(st[0], 1'b1);
        rd(swl_pkg::REG_STATUS, st);
        `CHK(st[swl_pkg::ST_BUSY], 1'b1);
        wr(swl_pkg::REG_CMD, swl_pkg::CMD_READ_BYTE);
        rd(swl_pkg::REG_ACK, st);
        `CHK(st[0], 1'b0);
        wr(swl_pkg::REG_ACK, 8'h80);
        wr(swl_pkg::REG_PARAM, swl_pkg::CMD_TRIPLET);
        rd(swl_pkg::REG_ACK, st);
        `CHK(st[0], 1'b0);
        wait_idle();
        `CHK(pulses, 8'h08);
        `CHK(last_len <= W1MAX, 1'b1);
        `CHK(gap < swl_pkg::SLOT_STD_CYC, 1'b1);
        rd(swl_pkg::REG_READ_DATA, s2);
        `CHK(s2, 8'h00);
        wr(swl_pkg::REG_PTR, 8'h01);
        rd(swl_pkg::REG_READ_DATA, s2);
        `CHK(s2, 8'hA5);
    endtask
    task automatic t_triplet(input logic [1:0] b, input logic v,
        input logic [7:0] cfg);
        logic w;
        w = (b[0] == b[1]) ? (b[0] | v) : b[0];
        arm(cfg, {6'h3F, b});
        wr(swl_pkg::REG_ACK, v ? 8'h80 : 8'h7F);
        wr(swl_pkg::REG_PARAM, swl_pkg::CMD_TRIPLET);
        rd(swl_pkg::REG_ACK, st);
        `CHK(st[0], 1'b1);
        rd(swl_pkg::REG_STATUS, st);
        `CHK(st[swl_pkg::ST_BUSY], 1'b1);
        wait_idle();
        `CHK(pulses, 8'h03);
        `CHK(st[swl_pkg::ST_SBR], b[0]);
        `CHK(st[swl_pkg::ST_TSB], b[1]);
        `CHK(st[swl_pkg::ST_DIR], w);
        if (cfg[swl_pkg::CFG_SPEED])
            `CHK(last_len <= W1MAX, w);
        else
        begin
            `CHK(gap >= swl_pkg::SLOT_STD_CYC, 1'b1);
            `CHK(pu_seen, 1'b1);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        arm(8'h08, 8'hFF);
        wr(4'hF, swl_pkg::CMD_READ_BYTE);
        repeat (40) @(posedge core_clk);
        `CHK(pulses, 8'h00);
        t_read_byte();
        // a few search steps, each one triplet
        for (int i = 0; i < 5; i++)
            t_triplet(tb_b[i], tb_v[i], 8'h08);
        t_triplet(2'h0, 1'b1, 8'h01);
        end_of_test();
    end
    initial
    begin
        repeat (90000) @(posedge core_clk);
        miscompares++;
        end_of_test();
    end
endmodule

// >>> tb/swl_slave_model.sv
// behavioural slave on the single-wire line, answers from a bit pattern
`timescale 1ns/100ps
module swl_slave_model
(
    input wire logic core_clk, // clock
    input wire logic line_oe, // master pulls low
    input wire logic pullup_o, // master active pullup
    input wire logic fast, // speed in use
    input wire logic [7:0] pattern, // answers, first slot in bit 0
    input wire logic restart, // back to first slot
    output logic line_lvl, // wired level, pulled up when free
    output logic [7:0] pulses, // low pulses seen
    output logic [15:0] last_len, // cycles of last low pulse
    output logic [15:0] gap, // cycles between last two falls
    output logic pu_seen // active pullup seen
);
    logic [15:0] hold = 16'h0000;
    logic [15:0] len = 16'h0000;
    logic [15:0] since = 16'h0000;
    logic oe_q = 1'b0;
    int hold_c;
    // zero answer held past the sample point, freed before slot end
    assign hold_c = fast ?
        (swl_pkg::SLOT_FAST_CYC + swl_pkg::SAMPLE_FAST_CYC) / 2 :
        (swl_pkg::SLOT_STD_CYC + swl_pkg::SAMPLE_STD_CYC) / 2;
    assign line_lvl = !(line_oe || hold != 16'h0000);
    always @(posedge core_clk)
    begin
        oe_q <= line_oe;
        since <= since + 16'h0001;
        len <= line_oe ? len + 16'h0001 : 16'h0000;
        if (hold != 16'h0000)
            hold <= hold - 16'h0001;
        if (line_oe && !oe_q)
        begin
            gap <= since;
            since <= 16'h0001;
            pulses <= pulses + 8'h01;
            if (!pattern[pulses[2:0]])
                hold <= 16'(hold_c);
        end
        if (!line_oe && oe_q)
            last_len <= len;
        if (pullup_o)
            pu_seen <= 1'b1;
        if (restart)
        begin
            pulses <= 8'h00;
            pu_seen <= 1'b0;
        end
    end
endmodule
